// *** rtl/tmiof_top.sv ***
// token manager slice: i/o token timers, priority fields, queue feedback
// assumes avalon-mm master on I_MCLK; level inputs arrive from other logic as pins
//
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module tmiof_top #(
  parameter int INTV_W = 8,
  parameter int PRE_W  = 4,
  parameter int CNT_W  = 32
) (
  input  wire logic                 I_MCLK,
  input  wire logic                 I_RST,
  input  wire logic [7:0]           I_ADDRESS,
  input  wire logic                 I_READ,
  input  wire logic                 I_WRITE,
  input  wire logic [31:0]          I_WRITEDATA,
  input  wire logic [3:0]           I_BYTEENABLE,
  output logic      [31:0]          O_READDATA,
  output logic                      O_WAITREQUEST,
  input  wire logic [1:0]           I_MEM_RD_LVL,
  input  wire logic [1:0]           I_MEM_WR_LVL,
  input  wire logic [1:0]           I_IO0_LVL,
  input  wire logic [1:0]           I_IO1_LVL,
  input  wire logic [1:0]           I_IO_COHERENT,
  input  wire logic [1:0]           I_IO_TOKEN_TAKE,
  output logic      [1:0]           O_IO_TOKEN_AVAIL,
  output logic [tmiof_pkg::NUM_RES-1:0] O_UNALLOC_OK,
  output logic [tmiof_pkg::NUM_RES-1:0] O_SHARE_OK,
  output logic [tmiof_pkg::NUM_RES-1:0] O_GEN_OK,
  output logic      [5:0]           O_UNALLOC_PRIO,
  output logic      [2:0]           O_G0_PRIO,
  output logic                      O_IRQ
);
  import tmiof_pkg::*;

  // longest period needs interval+1 bits plus the largest shift
  // interval and prescaler must also fit side by side in one 32-bit alloc word
  if (CNT_W < INTV_W + 1 + (1 << PRE_W) + IO1_PRE_EXTRA || CNT_W > 64
      || INTV_W > ALLOC_PRE_LSB || ALLOC_PRE_LSB + PRE_W > 32) begin : g_chk
    $error("tmiof_top: parameters do not fit the counter or the alloc fields");
  end

  function automatic logic [CNT_W-1:0] period_m1(input logic [INTV_W-1:0] iv,
                                                 input logic [PRE_W-1:0]  p,
                                                 input logic              stretch);
    logic [CNT_W-1:0] base;
    logic [PRE_W:0]   sh;
    base = CNT_W'(GEN_BASE) + CNT_W'(iv);
    sh   = {1'b0, p} + (stretch ? (PRE_W+1)'(IO1_PRE_EXTRA) : '0);
    return (base << sh) - CNT_W'(1);
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // big-endian bit number to vector index
  function automatic int pr_idx(input int n);
    return 63 - n;
  endfunction

  // ---- half-rate enable and level synchronisers
  logic                 half_ff, nxt_half;
  logic [9:0]           s1_ff, s2_ff;
  logic [1:0]           lvl_eff [NUM_RES];
  logic [1:0]           lvl_ff  [NUM_RES];
  logic [1:0]           nxt_lvl [NUM_RES];
  logic [NUM_RES-1:0]   unal_ff, share_ff, gen_ff;
  logic [NUM_RES-1:0]   nxt_unal, nxt_share, nxt_gen;
  logic [31:0]          ctrl_ff, nxt_ctrl;
  logic [NUM_RES-1:0]   isr_ff, nxt_isr;
  logic                 irq_ff, nxt_irq;
  logic                 fe;

  assign fe = ctrl_ff[CTRL_FE_BIT];

  always_comb begin
    logic [1:0] mr, mw;
    mr       = s2_ff[1:0];
    mw       = s2_ff[3:2];
    nxt_half = ~half_ff;
    lvl_eff[RES_MEM] = (mr > mw) ? mr : mw;
    // a bus running the coherent protocol gives no feedback, so reads as level 0
    lvl_eff[RES_IO0] = s2_ff[8] ? LVL_0 : s2_ff[5:4];
    lvl_eff[RES_IO1] = s2_ff[9] ? LVL_0 : s2_ff[7:6];
    for (int r = 0; r < NUM_RES; r++) begin
      nxt_lvl[r]   = half_ff ? lvl_eff[r] : lvl_ff[r];
      // level coding: 0 below t1, 1 up to t2, 2 up to t3, 3 at or above t3
      nxt_unal[r]  = half_ff ? (~fe || lvl_eff[r] == LVL_0) : unal_ff[r];
      nxt_share[r] = half_ff ? (~fe || lvl_eff[r] <= LVL_1) : share_ff[r];
      nxt_gen[r]   = half_ff ? (~fe || lvl_eff[r] != LVL_3) : gen_ff[r];
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      half_ff  <= 1'b0;
      s1_ff    <= '0;
      s2_ff    <= '0;
      unal_ff  <= '1;
      share_ff <= '1;
      gen_ff   <= '1;
      for (int r = 0; r < NUM_RES; r++) begin
        lvl_ff[r] <= LVL_0;
      end
    end else begin
      half_ff  <= nxt_half;
      s1_ff    <= {I_IO_COHERENT, I_IO1_LVL, I_IO0_LVL, I_MEM_WR_LVL, I_MEM_RD_LVL};
      s2_ff    <= s1_ff;
      unal_ff  <= nxt_unal;
      share_ff <= nxt_share;
      gen_ff   <= nxt_gen;
      for (int r = 0; r < NUM_RES; r++) begin
        lvl_ff[r] <= nxt_lvl[r];
      end
    end
  end

  // ---- avalon slave and register file
  logic                 ack_ff, nxt_ack;
  logic                 wait_ff, nxt_wait;
  logic [31:0]          rdata_ff, nxt_rdata;
  logic [63:0]          prio_ff, nxt_prio;
  logic [31:0]          alloc_ff [2];
  logic [31:0]          nxt_alloc [2];
  logic                 wr_now;
  logic [NUM_RES-1:0]   hit3;

  // one wait state: request seen, then answered on the following edge
  assign wr_now = I_WRITE && ack_ff;

  always_comb begin
    logic [NUM_RES-1:0] w1c;
    w1c       = '0;
    nxt_ack   = (I_READ || I_WRITE) && !ack_ff;
    nxt_wait  = !nxt_ack;
    nxt_ctrl  = ctrl_ff;
    nxt_prio  = prio_ff;
    nxt_alloc = alloc_ff;
    for (int r = 0; r < NUM_RES; r++) begin
      hit3[r] = half_ff && lvl_eff[r] == LVL_3;
    end
    if (wr_now) begin
      unique case (I_ADDRESS)
        OFS_CTRL:      nxt_ctrl = be_merge(ctrl_ff, I_WRITEDATA, I_BYTEENABLE);
        OFS_ISR:       w1c = I_BYTEENABLE[0] ? I_WRITEDATA[NUM_RES-1:0] : '0;
        OFS_PRIO_HI:   nxt_prio[63:32] = be_merge(prio_ff[63:32], I_WRITEDATA, I_BYTEENABLE);
        OFS_PRIO_LO:   nxt_prio[31:0] = be_merge(prio_ff[31:0], I_WRITEDATA, I_BYTEENABLE);
        OFS_IO0_ALLOC: nxt_alloc[0] = be_merge(alloc_ff[0], I_WRITEDATA, I_BYTEENABLE);
        OFS_IO1_ALLOC: nxt_alloc[1] = be_merge(alloc_ff[1], I_WRITEDATA, I_BYTEENABLE);
        default:       nxt_ctrl = ctrl_ff;
      endcase
    end
    // a level 3 in the same cycle as a clear keeps the bit set
    nxt_isr = (isr_ff & ~w1c) | hit3;
    nxt_irq = |(nxt_isr & nxt_ctrl[CTRL_IEN_LSB +: NUM_RES]);
    nxt_rdata = rdata_ff;
    if (nxt_ack && I_READ) begin
      unique case (I_ADDRESS)
        OFS_CTRL:      nxt_rdata = ctrl_ff;
        OFS_ISR:       nxt_rdata = 32'(isr_ff);
        OFS_PRIO_HI:   nxt_rdata = prio_ff[63:32];
        OFS_PRIO_LO:   nxt_rdata = prio_ff[31:0];
        OFS_IO0_ALLOC: nxt_rdata = alloc_ff[0];
        OFS_IO1_ALLOC: nxt_rdata = alloc_ff[1];
        OFS_LEVELS:    nxt_rdata = {24'h0, O_IO_TOKEN_AVAIL, lvl_ff[RES_IO1],
                                    lvl_ff[RES_IO0], lvl_ff[RES_MEM]};
        default:       nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      ack_ff   <= 1'b0;
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
      ctrl_ff  <= CTRL_RST;
      isr_ff   <= '0;
      irq_ff   <= 1'b0;
      prio_ff  <= PRIO_RST;
      alloc_ff <= '{ALLOC_RST, ALLOC_RST};
    end else begin
      ack_ff   <= nxt_ack;
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
      ctrl_ff  <= nxt_ctrl;
      isr_ff   <= nxt_isr;
      irq_ff   <= nxt_irq;
      prio_ff  <= nxt_prio;
      alloc_ff <= nxt_alloc;
    end
  end

  // ---- priority field decode, registered for the grant logic
  logic [5:0]           uprio_ff, nxt_uprio;
  logic [2:0]           g0prio_ff, nxt_g0prio;

  always_comb begin
    // six unallocated-group bits come from three fields, group 0 bits from two
    nxt_uprio  = {prio_ff[pr_idx(PR_FA_FIRST) -: 3],
                  prio_ff[pr_idx(PR_FB_FIRST) -: 2],
                  prio_ff[pr_idx(PR_FC_FIRST)]};
    nxt_g0prio = {prio_ff[pr_idx(PR_G0A_FIRST) -: 2],
                  prio_ff[pr_idx(PR_G0B_FIRST)]};
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      uprio_ff  <= '0;
      g0prio_ff <= '0;
    end else begin
      uprio_ff  <= nxt_uprio;
      g0prio_ff <= nxt_g0prio;
    end
  end

  // ---- i/o bus token decrementers, stepped on the half-rate enable
  logic [CNT_W-1:0]     cnt_ff  [2];
  logic [CNT_W-1:0]     nxt_cnt [2];
  logic [1:0]           avail_ff, nxt_avail;
  logic [1:0]           expire;

  always_comb begin
    for (int k = 0; k < 2; k++) begin
      expire[k] = half_ff && cnt_ff[k] == '0;
      nxt_cnt[k] = cnt_ff[k];
      if (expire[k]) begin
        // bus one runs four times slower for the same settings
        nxt_cnt[k] = period_m1(alloc_ff[k][INTV_W-1:0],
                               alloc_ff[k][ALLOC_PRE_LSB +: PRE_W],
                               k == 1);
      end else if (half_ff) begin
        nxt_cnt[k] = cnt_ff[k] - CNT_W'(1);
      end
      // a token only appears while generation is allowed; taking loses to a new token
      nxt_avail[k] = (avail_ff[k] && !I_IO_TOKEN_TAKE[k])
                     || (expire[k] && gen_ff[RES_IO0 + k]);
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      cnt_ff   <= '{default: '0};
      avail_ff <= 2'h0;
    end else begin
      cnt_ff   <= nxt_cnt;
      avail_ff <= nxt_avail;
    end
  end

  assign O_READDATA       = rdata_ff;
  assign O_WAITREQUEST    = wait_ff;
  assign O_IO_TOKEN_AVAIL = avail_ff;
  assign O_UNALLOC_OK     = unal_ff;
  assign O_SHARE_OK       = share_ff;
  assign O_GEN_OK         = gen_ff;
  assign O_UNALLOC_PRIO   = uprio_ff;
  assign O_G0_PRIO        = g0prio_ff;
  assign O_IRQ            = irq_ff;

  // ---- checks
  a_unal_level: assert property (@(posedge I_MCLK) disable iff (I_RST)
    half_ff && fe |=> O_UNALLOC_OK[RES_MEM] == ($past(lvl_eff[RES_MEM]) == LVL_0))
    else $error("unallocated grant permission wrong for memory level");
  a_share_level: assert property (@(posedge I_MCLK) disable iff (I_RST)
    half_ff && fe && lvl_eff[RES_IO0] >= LVL_2 |=> !O_SHARE_OK[RES_IO0])
    else $error("sharing allowed at level 2 or 3");
  a_gen_stop: assert property (@(posedge I_MCLK) disable iff (I_RST)
    !gen_ff[RES_IO0] && !avail_ff[0] |=> !avail_ff[0])
    else $error("token produced while generation stopped");
  a_fe_off: assert property (@(posedge I_MCLK) disable iff (I_RST)
    half_ff && !fe |=> O_UNALLOC_OK == '1 && O_SHARE_OK == '1 && O_GEN_OK == '1)
    else $error("feedback acted while disabled");
  a_isr_set: assert property (@(posedge I_MCLK) disable iff (I_RST)
    hit3[RES_IO1] |=> isr_ff[RES_IO1])
    else $error("level 3 did not set status");
  a_isr_sticky: assert property (@(posedge I_MCLK) disable iff (I_RST)
    isr_ff[RES_IO0] && !(wr_now && I_ADDRESS == OFS_ISR) |=> isr_ff[RES_IO0])
    else $error("status bit dropped without clear");
  a_irq_cause: assert property (@(posedge I_MCLK) disable iff (I_RST)
    ##1 O_IRQ == |($past(nxt_isr) & ctrl_ff[CTRL_IEN_LSB +: NUM_RES]))
    else $error("interrupt not tied to status and enable");
  a_mem_max: assert property (@(posedge I_MCLK) disable iff (I_RST)
    half_ff |=> lvl_ff[RES_MEM] >= $past(s2_ff[1:0]) && lvl_ff[RES_MEM] >= $past(s2_ff[3:2])
      && (lvl_ff[RES_MEM] == $past(s2_ff[1:0]) || lvl_ff[RES_MEM] == $past(s2_ff[3:2])))
    else $error("memory level not the highest count");
  a_coh_none: assert property (@(posedge I_MCLK) disable iff (I_RST)
    half_ff && s2_ff[9] |=> lvl_ff[RES_IO1] == LVL_0)
    else $error("coherent bus gave feedback");
  a_io0_period: assert property (@(posedge I_MCLK) disable iff (I_RST)
    expire[0] && alloc_ff[0][11:0] == 12'h000 |=> cnt_ff[0] == CNT_W'(8) [*2])
    else $error("bus zero period wrong");
  a_io1_period: assert property (@(posedge I_MCLK) disable iff (I_RST)
    expire[1] && alloc_ff[1][11:0] == 12'h000 |=> cnt_ff[1] == CNT_W'(35))
    else $error("bus one period wrong");
  a_prio_map: assert property (@(posedge I_MCLK) disable iff (I_RST)
    ##1 O_UNALLOC_PRIO == $past(prio_ff[29:24]))
    else $error("unallocated priority field misplaced");
endmodule

// *** rtl/tmiof_pkg.sv ***
// constants for the token manager i/o feedback block
// assumes one 100 mhz clock; the manager itself steps on a half-rate enable
// Functional notes
// - bus zero: one 128-byte token per (9+interval)*2^prescaler half-rate cycles.
// - bus one: period stretched by four, (9+interval)*2^(prescaler+2) cycles.
// - priority register: enables per borrowing group for each lending group.
// - unallocated-group six priority bits sit at priority bits 34 to 39.
// - group 0 unused-token priority bits sit at priority bits 43 to 45.
// - six-bit value spans three fields; three-bit values span two fields.
// - controllers report queue levels; coherent-protocol bus reports none.
// - levels 0..3 mean counts below, between and above thresholds 1..3.
// - queue levels alter grants only while feedback enable is set.
// - a level 3 report sets that resource's interrupt status bit.
// - interrupt raised while a status bit and its enable are both one.
// - unallocated tokens granted only at level 0.
// - unused tokens shared only at levels 0 and 1.
// - token generation continues through level 2, stops at level 3.
// - memory feedback is the highest of its read and write levels.
// - manager and decrementers step at half the core clock.
package tmiof_pkg;
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_ISR       = 8'h04;
  localparam logic [7:0]  OFS_PRIO_HI   = 8'h08;
  localparam logic [7:0]  OFS_PRIO_LO   = 8'h0c;
  localparam logic [7:0]  OFS_IO0_ALLOC = 8'h10;
  localparam logic [7:0]  OFS_IO1_ALLOC = 8'h14;
  localparam logic [7:0]  OFS_LEVELS    = 8'h18;
  localparam int          CTRL_FE_BIT   = 0;
  localparam int          CTRL_IEN_LSB  = 1;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam logic [31:0] ALLOC_RST     = 32'h0000_0000;
  localparam logic [63:0] PRIO_RST      = 64'h0000_0000_0000_0000;
  localparam int          ALLOC_PRE_LSB = 8;
  localparam int          NUM_RES       = 3;
  localparam int          RES_MEM       = 0;
  localparam int          RES_IO0       = 1;
  localparam int          RES_IO1       = 2;
  localparam int          GEN_BASE      = 9;
  localparam int          IO1_PRE_EXTRA = 2;
  localparam int          TOKEN_BYTES   = 128;
  // priority register bit numbers count from the msb of 64 bits
  localparam int          PR_FA_FIRST   = 34;
  localparam int          PR_FB_FIRST   = 37;
  localparam int          PR_FC_FIRST   = 39;
  localparam int          PR_G0A_FIRST  = 43;
  localparam int          PR_G0B_FIRST  = 45;
  localparam logic [1:0]  LVL_0         = 2'h0;
  localparam logic [1:0]  LVL_1         = 2'h1;
  localparam logic [1:0]  LVL_2         = 2'h2;
  localparam logic [1:0]  LVL_3         = 2'h3;
endpackage

// *** tb/tmiof_qfb_model.sv ***
// queue feedback model: memory and i/o controllers reporting queue levels
// assumes entry counts come from the bench; thresholds fixed by parameters
`timescale 1ns/10ps
module tmiof_qfb_model #(
  parameter int TH1 = 4,
  parameter int TH2 = 8,
  parameter int TH3 = 12
) (
  input  wire logic [7:0] i_mem_rd_cnt,
  input  wire logic [7:0] i_mem_wr_cnt,
  input  wire logic [7:0] i_io0_cnt,
  input  wire logic [7:0] i_io1_cnt,
  input  wire logic [1:0] i_coherent,
  output logic      [1:0] o_mem_rd_lvl,
  output logic      [1:0] o_mem_wr_lvl,
  output logic      [1:0] o_io0_lvl,
  output logic      [1:0] o_io1_lvl
);
  function automatic logic [1:0] lvl(input logic [7:0] c);
    if (c >= 8'(TH3)) return 2'h3;
    if (c >= 8'(TH2)) return 2'h2;
    if (c >= 8'(TH1)) return 2'h1;
    return 2'h0;
  endfunction
  assign o_mem_rd_lvl = lvl(i_mem_rd_cnt);
  assign o_mem_wr_lvl = lvl(i_mem_wr_cnt);
  // coherent bus gives no feedback: wire carries junk the block must ignore
  assign o_io0_lvl = i_coherent[0] ? 2'h3 : lvl(i_io0_cnt);
  assign o_io1_lvl = i_coherent[1] ? 2'h3 : lvl(i_io1_cnt);
endmodule

// *** tb/tb_top.sv ***
// bench: avalon register tasks, token timing, feedback and interrupt checks
// assumes the feedback model drives all queue level inputs
`timescale 1ns/10ps
module tb_top;
  import tmiof_pkg::*;
  logic        I_MCLK = 1'b0;
  logic        I_RST = 1'b1;
  logic [7:0]  I_ADDRESS = 8'h00;
  logic        I_READ = 1'b0;
  logic        I_WRITE = 1'b0;
  logic [31:0] I_WRITEDATA = 32'h0;
  logic [3:0]  I_BYTEENABLE = 4'hf;
  logic [1:0]  I_IO_COHERENT = 2'h0;
  logic [1:0]  I_IO_TOKEN_TAKE = 2'h0;
  logic [31:0] O_READDATA;
  logic        O_WAITREQUEST;
  logic [1:0]  mrl, mwl, q0l, q1l, O_IO_TOKEN_AVAIL;
  logic [2:0]  O_UNALLOC_OK, O_SHARE_OK, O_GEN_OK, O_G0_PRIO;
  logic [5:0]  O_UNALLOC_PRIO, pr;
  logic        O_IRQ;
  logic [7:0]  c_mr = 8'h0, c_mw = 8'h0, c_q0 = 8'h0, c_q1 = 8'h0;
  logic [31:0] rd, v;
  int          miscompares = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          t1, t2, t3;

  tmiof_qfb_model qfb (.i_mem_rd_cnt(c_mr), .i_mem_wr_cnt(c_mw), .i_io0_cnt(c_q0),
    .i_io1_cnt(c_q1), .i_coherent(I_IO_COHERENT), .o_mem_rd_lvl(mrl),
    .o_mem_wr_lvl(mwl), .o_io0_lvl(q0l), .o_io1_lvl(q1l));
  tmiof_top dut (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_ADDRESS(I_ADDRESS), .I_READ(I_READ),
    .I_WRITE(I_WRITE), .I_WRITEDATA(I_WRITEDATA), .I_BYTEENABLE(I_BYTEENABLE),
    .O_READDATA(O_READDATA), .O_WAITREQUEST(O_WAITREQUEST), .I_MEM_RD_LVL(mrl),
    .I_MEM_WR_LVL(mwl), .I_IO0_LVL(q0l), .I_IO1_LVL(q1l), .I_IO_COHERENT(I_IO_COHERENT),
    .I_IO_TOKEN_TAKE(I_IO_TOKEN_TAKE), .O_IO_TOKEN_AVAIL(O_IO_TOKEN_AVAIL),
    .O_UNALLOC_OK(O_UNALLOC_OK), .O_SHARE_OK(O_SHARE_OK), .O_GEN_OK(O_GEN_OK),
    .O_UNALLOC_PRIO(O_UNALLOC_PRIO), .O_G0_PRIO(O_G0_PRIO), .O_IRQ(O_IRQ));

  always #5 I_MCLK = ~I_MCLK;

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ceiling well above the longest token sequence
  always @(posedge I_MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is sampled low, released after that edge;
  // no limit of its own: a hung slave is ended by the cycle ceiling
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge I_MCLK);
    I_ADDRESS <= a;
    I_WRITEDATA <= d;
    I_WRITE <= w;
    I_READ <= !w;
    do begin
      @(posedge I_MCLK);
    end while (O_WAITREQUEST !== 1'b0);
    rd = O_READDATA;
    I_WRITE <= 1'b0;
    I_READ <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic settle();
    repeat (10) @(posedge I_MCLK);
  endtask

  // waits for a token of bus k, notes the cycle, then consumes it
  task automatic grab(input int k, output int t);
    do begin
      @(posedge I_MCLK);
    end while (O_IO_TOKEN_AVAIL[k] !== 1'b1);
    t = cyc;
    I_IO_TOKEN_TAKE[k] <= 1'b1;
    @(posedge I_MCLK);
    I_IO_TOKEN_TAKE[k] <= 1'b0;
  endtask

  initial begin
    int bk[3];
    int iv[3];
    int pv[3];
    bk = '{0, 0, 1};
    iv = '{1, 0, 2};
    pv = '{0, 1, 1};
    repeat (20) @(posedge I_MCLK);
    I_RST <= 1'b0;
    rdc(OFS_CTRL, CTRL_RST);
    rdc(OFS_ISR, 32'h0);
    rdc(OFS_PRIO_HI, PRIO_RST[63:32]);
    rdc(OFS_PRIO_LO, PRIO_RST[31:0]);
    rdc(OFS_IO1_ALLOC, ALLOC_RST);
    rdc(8'h1c, 32'h0);
    chk(O_GEN_OK & O_SHARE_OK & O_UNALLOC_OK, 3'h7);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, bk[i] ? OFS_IO1_ALLOC : OFS_IO0_ALLOC, 32'(iv[i] | (pv[i] << ALLOC_PRE_LSB)));
      rdc(bk[i] ? OFS_IO1_ALLOC : OFS_IO0_ALLOC, 32'(iv[i] | (pv[i] << ALLOC_PRE_LSB)));
      grab(bk[i], t1);
      grab(bk[i], t2);
      grab(bk[i], t3);
      chk(t3 - t2, ((GEN_BASE + iv[i]) << (pv[i] + IO1_PRE_EXTRA * bk[i])) * 2);
    end
    // software priority build: order 1,0,3,2 from highest
    pr = 6'h0;
    pr = (pr | 6'b000000) & 6'b110100;
    pr = (pr | 6'b111000) & 6'b111111;
    pr = (pr | 6'b000110) & 6'b011111;
    v = (32'(pr) << (63 - PR_FC_FIRST)) | (32'h5 << (63 - PR_G0B_FIRST));
    bus(1'b1, OFS_PRIO_LO, v);
    settle();
    chk(O_UNALLOC_PRIO, 6'h1e);
    chk(O_G0_PRIO, 3'h5);
    rdc(OFS_PRIO_LO, v);
    bus(1'b1, OFS_CTRL, 32'h1);
    for (int l = 0; l < 4; l++) begin
      c_q0 <= 8'(l * 4);
      settle();
      chk(O_UNALLOC_OK[RES_IO0], l == 0);
      chk(O_SHARE_OK[RES_IO0], l <= 1);
      chk(O_GEN_OK[RES_IO0], l <= 2);
      bus(1'b0, OFS_LEVELS, 32'h0);
      chk(rd[3:2], l);
    end
    rdc(OFS_ISR, 32'h2);
    chk(O_IRQ, 1'b0);
    I_IO_TOKEN_TAKE <= 2'h1;
    @(posedge I_MCLK);
    I_IO_TOKEN_TAKE <= 2'h0;
    repeat (60) @(posedge I_MCLK);
    chk(O_IO_TOKEN_AVAIL[0], 1'b0);
    bus(1'b1, OFS_CTRL, 32'h1 << (CTRL_IEN_LSB + RES_IO0));
    settle();
    chk(O_IRQ, 1'b1);
    chk(O_UNALLOC_OK, 3'h7);
    c_q0 <= 8'h0;
    settle();
    rdc(OFS_ISR, 32'h2);
    bus(1'b1, OFS_CTRL, 32'h0);
    settle();
    chk(O_IRQ, 1'b0);
    bus(1'b1, OFS_CTRL, 32'h1 << (CTRL_IEN_LSB + RES_IO0));
    bus(1'b1, OFS_ISR, 32'h2);
    settle();
    rdc(OFS_ISR, 32'h0);
    chk(O_IRQ, 1'b0);
    bus(1'b1, OFS_CTRL, 32'h1);
    c_mr <= 8'd4;
    c_mw <= 8'd8;
    c_q1 <= 8'd12;
    I_IO_COHERENT <= 2'h2;
    settle();
    chk(O_SHARE_OK[RES_MEM], 1'b0);
    chk(O_GEN_OK, 3'h7);
    bus(1'b0, OFS_LEVELS, 32'h0);
    chk(rd[5:0], 6'h02);
    rdc(OFS_ISR, 32'h0);
    I_IO_COHERENT <= 2'h0;
    settle();
    chk(O_GEN_OK[RES_IO1], 1'b0);
    rdc(OFS_ISR, 32'h4);
    conclude();
  end
endmodule
